// ---- src/lass_regs.vh ----
`ifndef LASS_REGS_VH
`define LASS_REGS_VH
// Number of pixels, one shift stage each
`define LASS_NPIX         128
`define LASS_PIX_W        7
// Clocks of integrator reset at the start of a scan
`define LASS_RESET_CLKS   8'h12
// Clock that ends the scan (129th)
`define LASS_END_CLK      8'h81
`define LASS_CNT_W        8
`define LASS_CNT_ZERO     8'h00
`define LASS_CNT_ONE      8'h01
// Charge transfer time, ns, and cycles at 8 ns
`define LASS_CHARGE_TRANSFER_NS  20000
`define LASS_CLK_NS              8
`endif

// ---- src/lass_scan_sequencer.v ----
// Summary of operation
// - One shift stage per pixel, advanced on each rising clock edge.
// - Start rising edge raises hold, disconnecting all samples and resetting integrators.
// - Advancing token selects each held pixel in turn, one per clock.
// - Integrators held in reset first 18 clocks, integration restarts on 19th.
// - 129th edge shifts token out and tri-states the analog output.
// - Output is high impedance whenever no readout is in progress.
// - Supplied clock alone governs transfer, stepping and integrator reset.
`include "lass_regs.vh"

module lass_scan_sequencer (
   input  wire                     MCLK_IN,
   input  wire                     RST_N_IN,
   input  wire                     START_IN,
   output reg  [`LASS_NPIX-1:0]    PIXEL_SELECT_OUT,
   output reg  [`LASS_PIX_W-1:0]   PIXEL_INDEX_OUT,
   output reg                      PIXEL_ANALOG_OUTPUT_OE_OUT,
   output reg                      HOLD_OUT,
   output reg                      INTEGRATOR_RESET_OUT,
   output reg                      INTEGRATING_OUT
);

   // ****************************************
   // Scan phases and helpers
   // ****************************************
   // Binary phase codes: only one phase is live at a time
   localparam [1:0] PH_IDLE  = 2'h0;  // No token inside, output released
   localparam [1:0] PH_RESET = 2'h1;  // Token inside, integrators in reset
   localparam [1:0] PH_READ  = 2'h2;  // Token inside, integration running

   // Clocks since start, held at the end value so it never wraps
   function [`LASS_CNT_W-1:0] count_up;
      input [`LASS_CNT_W-1:0] cnt;
      begin
         if (cnt == `LASS_END_CLK) begin
            count_up = cnt;
         end else begin
            count_up = cnt + `LASS_CNT_ONE;
         end
      end
   endfunction

   // Lowest set stage wins; an empty register reads as index zero
   function [`LASS_PIX_W-1:0] token_index;
      input [`LASS_NPIX-1:0] stages;
      integer k;
      begin
         token_index = {`LASS_PIX_W{1'b0}};
         for (k = `LASS_NPIX - 1; k >= 0; k = k - 1) begin
            if (stages[k]) begin
               token_index = k[`LASS_PIX_W-1:0];
            end
         end
      end
   endfunction

   // ****************************************
   // Internal state
   // ****************************************
   // Start pin synchroniser and edge detector
   reg                     start_meta_reg;
   reg                     start_sync_reg;
   reg                     start_prev_reg;
   // One stage per pixel; a set bit is the travelling token
   reg [`LASS_NPIX-1:0]    shift_reg;
   // Scan phase and clocks since the start edge
   reg [1:0]               phase_reg;
   reg [1:0]               phase_next;
   reg [`LASS_CNT_W-1:0]   clk_cnt_reg;
   reg [`LASS_CNT_W-1:0]   clk_cnt_next;
   // Next values of the control outputs
   reg                     hold_next;
   reg                     int_reset_next;
   reg                     integrating_next;
   // Decoded events
   wire                    start_rise;
   wire [`LASS_NPIX-1:0]   shift_next;
   wire                    scan_end;
   wire                    reset_done;
   wire [`LASS_PIX_W-1:0]  index_next;
   wire                    drive_next;

   // ****************************************
   // Start pin synchroniser and edge detect
   // ****************************************
   // Pin is asynchronous to the clock: two flops before any logic
   always @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         start_meta_reg <= 1'b0;
         start_sync_reg <= 1'b0;
         start_prev_reg <= 1'b0;
      end else begin
         start_meta_reg <= START_IN;
         start_sync_reg <= start_meta_reg;
         start_prev_reg <= start_sync_reg;
      end
   end

   // Edge flop resets to the idle pin level, so no false edge
   assign start_rise = start_sync_reg & ~start_prev_reg;

   // ****************************************
   // Token shift register
   // ****************************************
   // Token enters from the sampled start level; a start held high
   // breaks and loads extra tokens, as the real array would
   assign shift_next = {shift_reg[`LASS_NPIX-2:0], start_sync_reg};
   // The token leaving the last stage marks the 129th edge
   assign scan_end = shift_reg[`LASS_NPIX-1];
   // Output is driven only while a token is inside
   assign drive_next = |shift_next;
   // Pixel number shown after the next clock
   assign index_next = token_index(shift_next);

   // Shift on every edge: the clock alone steps the scan
   always @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         shift_reg <= {`LASS_NPIX{1'b0}};
      end else begin
         shift_reg <= shift_next;
      end
   end

   // ****************************************
   // Scan phase machine
   // ****************************************
   // Reset window ends once the 18th scan clock has been counted
   assign reset_done = (phase_reg == PH_RESET) && (clk_cnt_reg == `LASS_RESET_CLKS);

   // Next phase and count; a new start always reopens the reset
   // window, even in mid-scan, at the cost of a second token
   always @* begin
      phase_next   = phase_reg;
      clk_cnt_next = clk_cnt_reg;
      case (phase_reg)
         PH_IDLE: begin
            clk_cnt_next = `LASS_CNT_ZERO;
         end
         PH_RESET: begin
            if (reset_done) begin
               phase_next = PH_READ;
            end
            clk_cnt_next = count_up(clk_cnt_reg);
         end
         PH_READ: begin
            clk_cnt_next = count_up(clk_cnt_reg);
         end
         default: begin
            phase_next   = PH_IDLE;
            clk_cnt_next = `LASS_CNT_ZERO;
         end
      endcase
      if (scan_end) begin
         phase_next   = PH_IDLE;
         clk_cnt_next = `LASS_CNT_ZERO;
      end
      if (start_rise) begin
         phase_next   = PH_RESET;
         clk_cnt_next = `LASS_CNT_ONE;
      end
   end

   // Phase and count registers; the reset pin is a model aid only
   always @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         phase_reg   <= PH_IDLE;
         clk_cnt_reg <= `LASS_CNT_ZERO;
      end else begin
         phase_reg   <= phase_next;
         clk_cnt_reg <= clk_cnt_next;
      end
   end

   // ****************************************
   // Control outputs
   // ****************************************
   // A start edge wins over the end of a scan and over the reset
   // window, so a restart always gets a full reset period
   always @* begin
      hold_next        = HOLD_OUT;
      int_reset_next   = INTEGRATOR_RESET_OUT;
      integrating_next = INTEGRATING_OUT;
      if (reset_done) begin
         int_reset_next   = 1'b0;
         integrating_next = 1'b1;
      end
      if (scan_end) begin
         hold_next = 1'b0;
      end
      if (start_rise) begin
         hold_next        = 1'b1;
         int_reset_next   = 1'b1;
         integrating_next = 1'b0;
      end
   end

   // ****************************************
   // Registered outputs
   // ****************************************
   // Every output comes from a flop, so the far side sees no glitch
   always @(posedge MCLK_IN) begin
      if (!RST_N_IN) begin
         PIXEL_SELECT_OUT           <= {`LASS_NPIX{1'b0}};
         PIXEL_INDEX_OUT            <= {`LASS_PIX_W{1'b0}};
         PIXEL_ANALOG_OUTPUT_OE_OUT <= 1'b0;
         HOLD_OUT                   <= 1'b0;
         INTEGRATOR_RESET_OUT       <= 1'b0;
         INTEGRATING_OUT            <= 1'b0;
      end else begin
         PIXEL_SELECT_OUT           <= shift_next;
         PIXEL_INDEX_OUT            <= index_next;
         PIXEL_ANALOG_OUTPUT_OE_OUT <= drive_next;
         HOLD_OUT                   <= hold_next;
         INTEGRATOR_RESET_OUT       <= int_reset_next;
         INTEGRATING_OUT            <= integrating_next;
      end
   end

endmodule // lass_scan_sequencer

// ---- bench/lass_scan_sequencer_checker.sv ----
`include "lass_regs.vh"
module lass_chk (
   input wire                   MCLK_IN,
   input wire                   RST_N_IN,
   input wire                   START_IN,
   input wire [`LASS_NPIX-1:0]  PIXEL_SELECT_OUT,
   input wire [`LASS_PIX_W-1:0] PIXEL_INDEX_OUT,
   input wire                   PIXEL_ANALOG_OUTPUT_OE_OUT,
   input wire                   HOLD_OUT,
   input wire                   INTEGRATOR_RESET_OUT,
   input wire                   INTEGRATING_OUT
);
   timeunit 1ns / 1ns;
   // Short aliases
   wire       oe = PIXEL_ANALOG_OUTPUT_OE_OUT;
   wire       ir = INTEGRATOR_RESET_OUT;
   wire       ig = INTEGRATING_OUT;
   wire [6:0] ix = PIXEL_INDEX_OUT;
   default clocking @(posedge MCLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // Start edge latency covers the two-flop synchroniser
   scan_start_a: assert property ($rose(START_IN) |-> ##[3:4] $rose(oe)) else $error("start");
   scan_open_a: assert property ($rose(oe) |-> HOLD_OUT && ir && !ig && ix == 0) else $error("open");
   token_step_a: assert property (oe && $past(oe) |-> ix == $past(ix) + 7'h01) else $error("step");
   one_hot_a: assert property (oe |-> PIXEL_SELECT_OUT == 128'h1 << ix && HOLD_OUT) else $error("hot");
   reset_len_a: assert property ($fell(ir) |-> ig && ix == 7'h12) else $error("reset");
   integ_start_a: assert property ($rose(ig) |-> !ir && ix == 7'h12) else $error("integ");
   scan_end_a: assert property ($fell(oe) |-> $past(ix) == 7'h7f && !HOLD_OUT) else $error("end");
   idle_hiz_a: assert property (!oe |-> PIXEL_SELECT_OUT == 0 && ix == 0 && !ir) else $error("idle");
   cover property ($rose(oe));
   cover property ($fell(oe));
   cover property ($rose(ig));
endmodule // lass_chk
bind lass_scan_sequencer lass_chk u_chk (
   .MCLK_IN                    (MCLK_IN),
   .RST_N_IN                   (RST_N_IN),
   .START_IN                   (START_IN),
   .PIXEL_SELECT_OUT           (PIXEL_SELECT_OUT),
   .PIXEL_INDEX_OUT            (PIXEL_INDEX_OUT),
   .PIXEL_ANALOG_OUTPUT_OE_OUT (PIXEL_ANALOG_OUTPUT_OE_OUT),
   .HOLD_OUT                   (HOLD_OUT),
   .INTEGRATOR_RESET_OUT       (INTEGRATOR_RESET_OUT),
   .INTEGRATING_OUT            (INTEGRATING_OUT)
);

// ---- bench/lass_ctl.sv ----
module lass_ctl (
   input  wire  clk_in,
   input  wire  go_in,
   output logic start_out = 1'b0
);
   timeunit 1ns / 1ns;
   // High for one edge only, so a single token enters
   always @(negedge clk_in) start_out <= go_in && !start_out;
endmodule // lass_ctl

// ---- bench/lass_scan_sequencer_tb.sv ----
module lass_scan_sequencer_tb;
   timeunit 1ns / 1ns;
   logic MCLK_IN = 0, RST_N_IN = 0, go = 0, START_IN, HOLD_OUT;
   logic [127:0] PIXEL_SELECT_OUT;
   logic [6:0]   PIXEL_INDEX_OUT;
   logic         PIXEL_ANALOG_OUTPUT_OE_OUT, INTEGRATOR_RESET_OUT, INTEGRATING_OUT;
   int           fails = 0, n_tests = 0, cyc = 0, p;
   wire [10:0]   st = {PIXEL_INDEX_OUT, PIXEL_ANALOG_OUTPUT_OE_OUT, HOLD_OUT,
                       INTEGRATOR_RESET_OUT, INTEGRATING_OUT};
   // Row: offset after enable, index, {enable, hold, reset, integrating}
   logic [18:0]  rows [5] = '{{8'h00, 7'h00, 4'he}, {8'h11, 7'h11, 4'he},
      {8'h12, 7'h12, 4'hd}, {8'h7f, 7'h7f, 4'hd}, {8'h80, 7'h00, 4'h1}};
   lass_scan_sequencer dut (
      .MCLK_IN                    (MCLK_IN),
      .RST_N_IN                   (RST_N_IN),
      .START_IN                   (START_IN),
      .PIXEL_SELECT_OUT           (PIXEL_SELECT_OUT),
      .PIXEL_INDEX_OUT            (PIXEL_INDEX_OUT),
      .PIXEL_ANALOG_OUTPUT_OE_OUT (PIXEL_ANALOG_OUTPUT_OE_OUT),
      .HOLD_OUT                   (HOLD_OUT),
      .INTEGRATOR_RESET_OUT       (INTEGRATOR_RESET_OUT),
      .INTEGRATING_OUT            (INTEGRATING_OUT)
   );
   lass_ctl ctl (.clk_in(MCLK_IN), .go_in(go), .start_out(START_IN));
   task automatic cmp(input logic [127:0] g, e);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic close_out;
      $display("%0d checks, %0d fails", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic idle;
      cmp(PIXEL_SELECT_OUT, 0);
      cmp(st, 0);
   endtask
   // One start request, then walk the first n rows of the scan
   task automatic scan(input int n);
      @(posedge MCLK_IN) go <= 1;
      @(posedge MCLK_IN) go <= 0;
      for (p = 0; p < 9 && PIXEL_ANALOG_OUTPUT_OE_OUT !== 1'b1; p++) @(negedge MCLK_IN);
      p = 0;
      for (int r = 0; r < n; r++) begin
         repeat (rows[r][18:11] - p) @(negedge MCLK_IN);
         p = rows[r][18:11];
         cmp(st, rows[r][10:0]);
         cmp(PIXEL_SELECT_OUT, rows[r][3] ? 128'h1 << rows[r][10:4] : 0);
      end
      $display("scan of %0d rows done", n);
   endtask
   initial forever #4 MCLK_IN = ~MCLK_IN;
   // Hang guard, well above the expected run of about 4500 cycles
   always @(posedge MCLK_IN) if (++cyc > 8000) begin
      fails++;
      close_out;
   end
   initial begin
      repeat (6) @(negedge MCLK_IN);
      idle;
      $display("reset idle check done");
      RST_N_IN = 1;
      scan(5);
      // Gap covers the 20 us transfer and the 33.75 us shortest
      // integration at this clock; clock keeps running meanwhile
      repeat (4300) @(negedge MCLK_IN);
      cmp(INTEGRATING_OUT, 1);
      scan(2);
      RST_N_IN = 0;
      repeat (2) @(negedge MCLK_IN);
      idle;
      $display("reset mid scan done");
      close_out;
   end
endmodule // lass_scan_sequencer_tb
